// ===== rtl/exc_mon.sv
// exception event monitor: range protection, uninitialised reads, stack and counter checks
// assumes target bus strobes and task/os indications are synchronous to ref_clk
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module exc_mon
    import exc_mon_pkg::*;
#(
    parameter int TRACE_DEPTH = 4096
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      bus_rd,
    input  wire logic                      bus_wr,
    input  wire logic                      bus_fetch,
    input  wire logic [exc_mon_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic                      os_code,
    input  wire logic [exc_mon_pkg::ADDR_W-1:0] sp_value,
    input  wire logic [2:0]                task_id,
    input  wire logic                      perf_tick,
    input  wire logic                      prof_tick,
    input  wire logic                      prof_pass,
    input  wire logic                      trace_wr,
    output logic                           break_req,
    output logic                           trace_point,
    output logic                           warn_ev
);
    import exc_mon_pkg::*;

    logic [31:0]            ctrl_ff;
    logic [NEV-1:0]         status_ff;
    logic [ADDR_W-1:0]      sp_lo_ff, sp_hi_ff;
    logic [ADDR_W-1:0]      blk_start_ff [NBLK];
    logic [ADDR_W-1:0]      blk_end_ff   [NBLK];
    logic [2:0]             blk_attr_ff  [NBLK];
    logic [NBLK-1:0]        blk_en_ff;
    logic [ADDR_W-1:0]      tsk_lo_ff    [NTASK];
    logic [ADDR_W-1:0]      tsk_hi_ff    [NTASK];
    logic [(1<<INIT_AW)-1:0] written_ff;
    logic [2:0]             task_ff;
    logic                   task_vld_ff;
    logic [PERF_W-1:0]      perf_ff;
    logic [PROF_TIME_W-1:0] prof_time_ff;
    logic [PROF_CNT_W-1:0]  prof_cnt_ff;
    logic [$clog2(TRACE_DEPTH+1)-1:0] trace_fill_ff;

    logic            apb_wr, apb_rd;
    logic [NBLK-1:0] blk_viol;
    logic [NEV-1:0]  ev;
    logic [INIT_AW-1:0] widx;
    logic            tstack_hit;

    assign apb_wr = psel && penable && pwrite && clk_en;
    assign apb_rd = psel && !penable && !pwrite;

    // per-block range compare and attribute check
    genvar g;
    generate
        for (g = 0; g < NBLK; g++) begin : g_blk
            logic hit;
            assign hit = blk_en_ff[g] && (bus_addr >= blk_start_ff[g])
                         && (bus_addr <= blk_end_ff[g]);
            always_comb begin
                blk_viol[g] = 1'b0;
                if (hit) begin
                    case (blk_attr_ff[g])
                        ATTR_RW:  blk_viol[g] = 1'b0;
                        ATTR_RO:  blk_viol[g] = bus_wr;
                        ATTR_WO:  blk_viol[g] = bus_rd;
                        ATTR_DIS: blk_viol[g] = bus_rd | bus_wr | bus_fetch;
                        ATTR_OS:  blk_viol[g] = (bus_rd | bus_wr | bus_fetch)
                                                & ~os_code;
                        default:  blk_viol[g] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // uninitialised tracking covers the low words of the space; words above are not tracked
    assign widx = bus_addr[INIT_AW:1];

    always_comb begin
        tstack_hit = 1'b0;
        for (int t = 0; t < NTASK; t++) begin
            if (t[2:0] != task_id && bus_wr && bus_addr >= tsk_lo_ff[t]
                && bus_addr <= tsk_hi_ff[t] && tsk_hi_ff[t] != '0) begin
                tstack_hit = 1'b1;
            end
        end
    end

    always_comb begin
        ev            = '0;
        ev[ST_PROT]   = |blk_viol;
        ev[ST_UNINIT] = bus_rd && (bus_addr[ADDR_W-1:INIT_AW+1] == '0)
                        && !written_ff[widx];
        ev[ST_STACK]  = (sp_value < sp_lo_ff) || (sp_value > sp_hi_ff);
        ev[ST_PERF]   = perf_tick && (&perf_ff);
        ev[ST_PROF]   = (prof_tick && (&prof_time_ff))
                        || (prof_pass && (&prof_cnt_ff));
        ev[ST_TRACE]  = trace_wr
                        && (trace_fill_ff == TRACE_DEPTH[$bits(trace_fill_ff)-1:0]);
        ev[ST_TSTACK] = tstack_hit;
        ev[ST_DISP]   = task_vld_ff && (task_id != task_ff);
    end

    // configuration writes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff  <= CTRL_RST;
            sp_lo_ff <= '0;
            sp_hi_ff <= '1;
            blk_en_ff <= '0;
            for (int i = 0; i < NBLK; i++) begin
                blk_start_ff[i] <= '0;
                blk_end_ff[i]   <= '0;
                blk_attr_ff[i]  <= ATTR_RW;
            end
            for (int i = 0; i < NTASK; i++) begin
                tsk_lo_ff[i] <= '0;
                tsk_hi_ff[i] <= '0;
            end
        end else if (apb_wr) begin
            if (paddr == OFS_CTRL) ctrl_ff <= pwdata;
            if (paddr == OFS_SP_LO) sp_lo_ff <= pwdata[ADDR_W-1:0];
            if (paddr == OFS_SP_HI) sp_hi_ff <= pwdata[ADDR_W-1:0];
            for (int i = 0; i < NBLK; i++) begin
                if (paddr == OFS_BLK_BASE + 12'(i*16))
                    blk_start_ff[i] <= pwdata[ADDR_W-1:0];
                if (paddr == OFS_BLK_BASE + 12'(i*16+4))
                    blk_end_ff[i] <= pwdata[ADDR_W-1:0];
                if (paddr == OFS_BLK_BASE + 12'(i*16+8)) begin
                    blk_attr_ff[i] <= pwdata[2:0];
                    blk_en_ff[i]   <= pwdata[31];
                end
            end
            for (int i = 0; i < NTASK; i++) begin
                if (paddr == OFS_TSK_BASE + 12'(i*8)) tsk_lo_ff[i] <= pwdata[ADDR_W-1:0];
                if (paddr == OFS_TSK_BASE + 12'(i*8+4)) tsk_hi_ff[i] <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // sticky status: write one to clear, a new event wins over the clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_ff <= '0;
        end else if (clk_en) begin
            status_ff <= (status_ff & ~((apb_wr && paddr == OFS_STATUS) ? pwdata[NEV-1:0]
                                        : {NEV{1'b0}})) | ev;
        end
    end

    // written-word map
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            written_ff <= '0;
        end else if (clk_en) begin
            if (bus_wr && bus_addr[ADDR_W-1:INIT_AW+1] == '0)
                written_ff[widx] <= 1'b1;
        end
    end

    // task tracking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            task_ff     <= '0;
            task_vld_ff <= 1'b0;
        end else if (clk_en) begin
            task_ff     <= task_id;
            task_vld_ff <= 1'b1;
        end
    end

    // measurement counters, wrapping naturally
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            perf_ff      <= '0;
            prof_time_ff <= '0;
            prof_cnt_ff  <= '0;
        end else if (clk_en) begin
            if (perf_tick) perf_ff <= perf_ff + 1'b1;
            if (prof_tick) prof_time_ff <= prof_time_ff + 1'b1;
            if (prof_pass) prof_cnt_ff <= prof_cnt_ff + 1'b1;
        end
    end

    // trace fill level saturates at capacity; extra writes are the overflow
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trace_fill_ff <= '0;
        end else if (clk_en) begin
            if (trace_wr && trace_fill_ff != TRACE_DEPTH[$bits(trace_fill_ff)-1:0])
                trace_fill_ff <= trace_fill_ff + 1'b1;
        end
    end

    // qualified outputs, one cycle after the event
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            break_req   <= 1'b0;
            trace_point <= 1'b0;
            warn_ev     <= 1'b0;
        end else if (clk_en) begin
            break_req   <= |(ev & ctrl_ff[CT_BRK_LO +: NEV]);
            trace_point <= |(ev & ctrl_ff[CT_TRC_LO +: NEV]);
            warn_ev     <= ev[ST_PROT] && ctrl_ff[CT_WARN];
        end
    end

    // apb: zero wait states, data prepared in setup cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (apb_rd) begin
                case (paddr)
                    OFS_CTRL:     prdata <= ctrl_ff;
                    OFS_STATUS:   prdata <= 32'(status_ff);
                    OFS_SP_LO:    prdata <= 32'(sp_lo_ff);
                    OFS_SP_HI:    prdata <= 32'(sp_hi_ff);
                    OFS_CUR_TASK: prdata <= 32'(task_ff);
                    OFS_PROF_CNT: prdata <= 32'(prof_cnt_ff);
                    OFS_PROF_TLO: prdata <= prof_time_ff[31:0];
                    OFS_PROF_THI: prdata <= 32'(prof_time_ff[PROF_TIME_W-1:32]);
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // exc_mon

// ===== rtl/exc_mon_pkg.sv
// constants, register map and encodings of the exception event monitor
// assumes a 100 MHz ref_clk, an APB master and target bus strobes on the same clock
//
// What this block does
// - flag any bus access whose kind the region attribute forbids
// - remember written words among the low 1024 words; flag reads of never-written words there
// - flag stack pointer outside configured low and high bounds
// - flag when the section time counter wraps past its maximum
// - flag profile overflow when profile time or pass count overflows
// - profile time is accumulated in a 40-bit counter
// - profile pass count is 16 bits, max 65535; passing it overflows
// - flag when trace memory fills beyond its capacity
// - flag a task writing into another task's stack region
// - raise an event on every task switch
// - attributes settable per word for any address range
// - read-write regions allow reads and writes
// - read-only regions flag writes
// - write-only regions flag reads
// - disabled regions flag reads, writes and fetches
// - os-only regions flag any access not issued by os code
// - after reset every address is read-write
// - sixteen range blocks check protection; regions beyond them stay unchecked
// - violation can qualify the hardware breakpoint
// - violation can qualify a trace point
// - violation reported as warning when warnings are enabled
package exc_mon_pkg;
    localparam int          ADDR_W        = 24;
    localparam int          NBLK          = 16;
    localparam int          PROF_TIME_W   = 40;
    localparam int          PROF_CNT_W    = 16;
    localparam int          PERF_W        = 32;
    localparam int          NTASK         = 8;
    localparam int          INIT_AW       = 10;
    // attribute codes
    localparam logic [2:0]  ATTR_RW       = 3'h0;
    localparam logic [2:0]  ATTR_RO       = 3'h1;
    localparam logic [2:0]  ATTR_WO       = 3'h2;
    localparam logic [2:0]  ATTR_DIS      = 3'h3;
    localparam logic [2:0]  ATTR_OS       = 3'h4;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_STATUS    = 12'h004;
    localparam logic [11:0] OFS_SP_LO     = 12'h008;
    localparam logic [11:0] OFS_SP_HI     = 12'h00C;
    localparam logic [11:0] OFS_CUR_TASK  = 12'h010;
    localparam logic [11:0] OFS_PROF_CNT  = 12'h014;
    localparam logic [11:0] OFS_PROF_TLO  = 12'h018;
    localparam logic [11:0] OFS_PROF_THI  = 12'h01C;
    localparam logic [11:0] OFS_BLK_BASE  = 12'h100; // 3 words per block, 16 stride
    localparam logic [11:0] OFS_TSK_BASE  = 12'h200; // 2 words per task, 8 stride
    // status bit positions
    localparam int          ST_PROT       = 0;
    localparam int          ST_UNINIT     = 1;
    localparam int          ST_STACK      = 2;
    localparam int          ST_PERF       = 3;
    localparam int          ST_PROF       = 4;
    localparam int          ST_TRACE      = 5;
    localparam int          ST_TSTACK     = 6;
    localparam int          ST_DISP       = 7;
    localparam int          NEV           = 8;
    // ctrl fields
    localparam int          CT_WARN       = 0;
    localparam int          CT_BRK_LO     = 8;
    localparam int          CT_TRC_LO     = 16;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
endpackage

// ===== tb/exc_mon_properties.sv
// checker: apb timing and block 0 protection relations on exc_mon ports
// assumes only block 0 is set up while the quiet check is armed
`timescale 1ns/1ps
module exc_mon_chk
    import exc_mon_pkg::*;
(
    input wire logic                      ref_clk,
    input wire logic                      rst_b,
    input wire logic                      clk_en,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      bus_rd,
    input wire logic                      bus_wr,
    input wire logic                      bus_fetch,
    input wire logic [exc_mon_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                      os_code,
    input wire logic [2:0]                task_id,
    input wire logic                      break_req,
    input wire logic                      trace_point,
    input wire logic                      warn_ev
);
    import exc_mon_pkg::*;
    logic [31:0]       ctrl_ff, attr_ff;
    logic [ADDR_W-1:0] lo_ff, hi_ff;
    logic              oth_ff, wa, acc, in0, vio;
    logic [2:0]        at;
    assign wa = psel && penable && pwrite && clk_en;
    assign acc = bus_rd || bus_wr || bus_fetch;
    assign in0 = bus_addr >= lo_ff && bus_addr <= hi_ff;
    assign at = attr_ff[2:0];
    assign vio = attr_ff[31] && in0 && ((at == ATTR_RO && bus_wr) || (at == ATTR_WO && bus_rd)
        || (at == ATTR_DIS && acc) || (at == ATTR_OS && acc && !os_code));
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RST;
            attr_ff <= '0;
            lo_ff <= '0;
            hi_ff <= '0;
            oth_ff <= 1'b0;
        end else if (wa) begin
            if (paddr == OFS_CTRL) ctrl_ff <= pwdata;
            if (paddr == OFS_BLK_BASE) lo_ff <= pwdata[ADDR_W-1:0];
            if (paddr == OFS_BLK_BASE + 12'h004) hi_ff <= pwdata[ADDR_W-1:0];
            if (paddr == OFS_BLK_BASE + 12'h008) attr_ff <= pwdata;
            if (paddr > OFS_BLK_BASE + 12'h008 && paddr < OFS_TSK_BASE) oth_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_ready_acc; psel && penable |-> pready; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("no pready in access");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready too long");
    property p_no_err; !pslverr; endproperty
    a_no_err: assert property (p_no_err) else $error("pslverr raised");
    property p_prot_warn; clk_en && vio && ctrl_ff[CT_WARN] |=> warn_ev; endproperty
    a_prot_warn: assert property (p_prot_warn) else $error("no warning");
    property p_prot_brk; clk_en && vio && ctrl_ff[CT_BRK_LO+ST_PROT] |=> break_req; endproperty
    a_prot_brk: assert property (p_prot_brk) else $error("no break");
    property p_prot_trc; clk_en && vio && ctrl_ff[CT_TRC_LO+ST_PROT] |=> trace_point; endproperty
    a_prot_trc: assert property (p_prot_trc) else $error("no trace point");
    property p_quiet; clk_en && !oth_ff && !(attr_ff[31] && in0) |=> !warn_ev; endproperty
    a_quiet: assert property (p_quiet) else $error("warning outside blocks");
    property p_warn_src; warn_ev |-> $past(acc) && $past(ctrl_ff[CT_WARN]); endproperty
    a_warn_src: assert property (p_warn_src) else $error("warning without cause");
    property p_disp;
        clk_en && task_id != $past(task_id) && ctrl_ff[CT_BRK_LO+ST_DISP] |=> break_req;
    endproperty
    a_disp: assert property (p_disp) else $error("no break on switch");
endmodule // exc_mon_chk
bind exc_mon exc_mon_chk u_exc_mon_chk (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .bus_rd      (bus_rd),
    .bus_wr      (bus_wr),
    .bus_fetch   (bus_fetch),
    .bus_addr    (bus_addr),
    .os_code     (os_code),
    .task_id     (task_id),
    .break_req   (break_req),
    .trace_point (trace_point),
    .warn_ev     (warn_ev)
);

// ===== tb/tb_top.sv
// self-checking bench for exc_mon: registers over apb and each event kind
// assumes tgt_bus drives target accesses and the checker is bound in
`timescale 1ns/1ps
module tb_top;
    import exc_mon_pkg::*;
    logic        ref_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr;
    logic        bus_rd, bus_wr, bus_fetch, os_code, perf_tick, prof_tick, prof_pass;
    logic        trace_wr, break_req, trace_point, warn_ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] bus_addr, sp_value;
    logic [2:0]  task_id;
    int          err_count, checks, cyc;
    exc_mon #(
        .TRACE_DEPTH (8)
    ) u_exc_mon (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .bus_rd      (bus_rd),
        .bus_wr      (bus_wr),
        .bus_fetch   (bus_fetch),
        .bus_addr    (bus_addr),
        .os_code     (os_code),
        .sp_value    (sp_value),
        .task_id     (task_id),
        .perf_tick   (perf_tick),
        .prof_tick   (prof_tick),
        .prof_pass   (prof_pass),
        .trace_wr    (trace_wr),
        .break_req   (break_req),
        .trace_point (trace_point),
        .warn_ev     (warn_ev)
    );
    tgt_bus u_tgt_bus (
        .ref_clk     (ref_clk),
        .bus_rd      (bus_rd),
        .bus_wr      (bus_wr),
        .bus_fetch   (bus_fetch),
        .bus_addr    (bus_addr),
        .os_code     (os_code)
    );
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // an idle edge first, so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic ev(input int b, input logic e);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk({31'h0, q[b]}, {31'h0, e});
        apb(1'b1, OFS_STATUS, 32'h0000_00FF);
    endtask
    task automatic pulse(input int n, input int b, input logic e);
        if (b == ST_PROF) prof_pass <= 1'b1; else trace_wr <= 1'b1;
        repeat (n) @(posedge ref_clk);
        {prof_pass, trace_wr} <= 2'b00;
        ev(b, e);
    endtask
    task automatic t_prot;
        logic [23:0] ad [3] = '{24'h00_0FFF, 24'h00_1000, 24'h00_10FF};
        logic v;
        apb(1'b1, OFS_BLK_BASE, 32'h0000_1000);
        apb(1'b1, OFS_BLK_BASE + 12'h004, 32'h0000_10FF);
        for (int at = 0; at < 5; at++) begin
            apb(1'b1, OFS_BLK_BASE + 12'h008, 32'h8000_0000 | at);
            for (int k = 0; k < 3; k++)
                for (int i = 0; i < 6; i++) begin
                    v = (i % 3 != 0) && ((at == ATTR_RO && k == 1) || (at == ATTR_WO && k == 0)
                        || at == ATTR_DIS || (at == ATTR_OS && i < 3));
                    u_tgt_bus.access(3'h1 << k, ad[i % 3], i >= 3);
                    if (!(k == 2 && (at == ATTR_RO || at == ATTR_WO)))
                        ev(ST_PROT, v);
                end
        end
        apb(1'b1, OFS_BLK_BASE + 12'h008, 32'h0000_0000);
    endtask
    // ticks while clk_en is low must not count
    task automatic t_cnt;
        prof_tick <= 1'b1;
        perf_tick <= 1'b1;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        {clk_en, prof_tick, perf_tick} <= 3'b100;
        apb(1'b0, OFS_PROF_TLO, 32'h0000_0000);
        chk(q, 32'h0000_0003);
        apb(1'b0, OFS_PROF_THI, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        ev(ST_PERF, 1'b0);
    endtask
    // a live stack error must vanish with a mid-run reset
    task automatic t_reset;
        apb(1'b1, OFS_SP_LO, 32'h0000_0300);
        ev(ST_STACK, 1'b1);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, OFS_SP_LO, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
    endtask
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, sp_value, task_id} = '0;
        {perf_tick, prof_tick, prof_pass, trace_wr, clk_en} = 5'h01;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk(q, CTRL_RST);
        apb(1'b1, 12'h080, 32'hFFFF_FFFF);
        apb(1'b0, 12'h080, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        u_tgt_bus.access(3'h2, 24'h00_3000, 1'b0);
        ev(ST_PROT, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h00FF_FF01);
        t_prot;
        u_tgt_bus.access(3'h1, 24'h00_0020, 1'b0);
        ev(ST_UNINIT, 1'b1);
        u_tgt_bus.access(3'h2, 24'h00_0020, 1'b0);
        u_tgt_bus.access(3'h1, 24'h00_0020, 1'b0);
        ev(ST_UNINIT, 1'b0);
        sp_value <= 24'h00_0150;
        apb(1'b1, OFS_SP_LO, 32'h0000_0100);
        apb(1'b1, OFS_SP_HI, 32'h0000_01FF);
        ev(ST_STACK, 1'b0);
        sp_value <= 24'h00_0200;
        ev(ST_STACK, 1'b1);
        sp_value <= 24'h00_01FF;
        apb(1'b1, OFS_STATUS, 32'h0000_00FF);
        ev(ST_STACK, 1'b0);
        apb(1'b1, OFS_TSK_BASE + 12'h008, 32'h0000_0400);
        apb(1'b1, OFS_TSK_BASE + 12'h00C, 32'h0000_04FF);
        task_id <= 3'h1;
        ev(ST_DISP, 1'b1);
        u_tgt_bus.access(3'h2, 24'h00_0410, 1'b0);
        ev(ST_TSTACK, 1'b0);
        task_id <= 3'h0;
        u_tgt_bus.access(3'h2, 24'h00_0410, 1'b0);
        ev(ST_TSTACK, 1'b1);
        pulse(65535, ST_PROF, 1'b0);
        apb(1'b0, OFS_PROF_CNT, 32'h0000_0000);
        chk(q, 32'h0000_FFFF);
        pulse(1, ST_PROF, 1'b1);
        pulse(8, ST_TRACE, 1'b0);
        pulse(1, ST_TRACE, 1'b1);
        apb(1'b1, OFS_BLK_BASE + 12'h0F0, 32'h0000_2000);
        apb(1'b1, OFS_BLK_BASE + 12'h0F4, 32'h0000_2000);
        apb(1'b1, OFS_BLK_BASE + 12'h0F8, 32'h8000_0003);
        u_tgt_bus.access(3'h4, 24'h00_2000, 1'b1);
        ev(ST_PROT, 1'b1);
        t_cnt;
        t_reset;
        test_done;
    end
    task automatic test_done;
        $display("err_count %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            test_done;
        end
    end
endmodule // tb_top

// ===== tb/tgt_bus.sv
// target bus model: one access per call, then the bus is released
// assumes the caller stands just past a rising edge of ref_clk
`timescale 1ns/1ps
module tgt_bus
    import exc_mon_pkg::*;
(
    input  wire logic                           ref_clk,
    output logic                                bus_rd,
    output logic                                bus_wr,
    output logic                                bus_fetch,
    output logic [exc_mon_pkg::ADDR_W-1:0]      bus_addr,
    output logic                                os_code
);
    initial begin
        {bus_fetch, bus_wr, bus_rd} = 3'h0;
        bus_addr = '0;
        os_code = 1'b0;
    end
    // released address and os_code show the inverse, strobes drop to zero, so a stale address never looks live
    // an idle edge first, so two calls in a row never drive the strobes twice in one step
    task automatic access(input logic [2:0] kind, input logic [ADDR_W-1:0] a, input logic os);
        @(posedge ref_clk);
        {bus_fetch, bus_wr, bus_rd} <= kind;
        bus_addr <= a;
        os_code <= os;
        @(posedge ref_clk);
        {bus_fetch, bus_wr, bus_rd} <= 3'h0;
        bus_addr <= ~a;
        os_code <= ~os;
    endtask
endmodule // tgt_bus
